//--- verilog/eeelpi_port.sv
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - low-power idle only at 100 Mbps, never on the host-facing port
// - request idle after fifo empty for programmed microseconds; zero allowed
// - fifo becoming non-empty restarts the empty timer from zero
// - active idle request drops as soon as the fifo is non-empty
// - empty timer held at zero while enable bit is clear
// - request only with enable, 100 Mbps, full duplex, both ends capable
// - link must be up continuously one second before requesting
// - requests and phy signalling ignore the mac transmit enable bit
// - idle signalled as tx enable low, error high, data 0001
// - frame in progress finishes before idle is signalled
// - after idle ends wait wake time plus inter-packet gap
// - count idle signalling rising edges; read-only, zero while disabled
// - count idle microseconds excluding wake; read-only, zero disabled
// - decode receive idle only under the same eligibility conditions
// - link up continuously one second before receive idle decoded
// - receive idle decoded even when mac receive enable is clear
// - count receive idle rising edges; read-only, zero while disabled
// - count receive idle microseconds; read-only, zero while disabled
module eeelpi_port #(
  parameter bit          HOST_PORT = 1'b0,
  parameter int unsigned LINK_US   = eeelpi_pkg::LINK_STABLE_US,
  parameter int unsigned CNT_W     = 32
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata,
  input  wire logic                     tx_fifo_empty,
  input  wire eeelpi_pkg::eeelpi_mii_s  mac_tx,
  output logic                          tx_start_ok,
  output eeelpi_pkg::eeelpi_mii_s       phy_tx,
  input  wire eeelpi_pkg::eeelpi_mii_s  phy_rx,
  input  wire logic                     link_up,
  input  wire logic                     speed_100,
  input  wire logic                     full_duplex,
  input  wire logic                     an_eee_100,
  output logic                          mac_transmit_enable,
  output logic                          mac_receive_enable,
  output logic                          rx_lpi_active
);
  import eeelpi_pkg::*;

  localparam int unsigned LNK_W = $clog2(LINK_US + 1);

  initial begin
    if (CNT_W < 8 || CNT_W > 32 || LINK_US == 0 || CYC_PER_US < 2
        || CYC_PER_US > 32 || IPG_CYC < 1 || IPG_CYC > 32) begin
      $error("eeelpi_port: unsupported parameter values");
    end
  end

  // registers
  logic              energy_saving_enable_q, energy_saving_enable_d;
  logic              txe_q, txe_d, rxe_q, rxe_d;
  logic [31:0]       tx_idle_request_delay_q, tx_idle_request_delay_d;
  logic [31:0]       tx_wake_wait_time_q, tx_wake_wait_time_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [CNT_W-1:0]  tx_trans_q, tx_trans_d, tx_time_q, tx_time_d;
  logic [CNT_W-1:0]  rx_trans_q, rx_trans_d, rx_time_q, rx_time_d;

  // timers and state
  logic [4:0]        tick_cnt_q, tick_cnt_d;
  logic              tick;
  logic [LNK_W-1:0]  link_cnt_q, link_cnt_d;
  logic              link_stable;
  logic              eligible;
  logic [31:0]       empty_us_q, empty_us_d;
  logic              client_req;
  eeelpi_state_e     state_q, state_d;
  logic [31:0]       wake_us_q, wake_us_d;
  logic [4:0]        ipg_cnt_q, ipg_cnt_d;
  eeelpi_mii_s       phy_tx_q, phy_tx_d;
  logic              rx_lpi_now, rx_lpi_q;

  assign reg_rdata           = rdata_q;
  assign phy_tx              = phy_tx_q;
  assign mac_transmit_enable = txe_q;
  assign mac_receive_enable  = rxe_q;
  assign rx_lpi_active       = rx_lpi_q;
  assign tx_start_ok         = (state_q == ST_RUN);

  // microsecond tick and link stability
  always_comb begin
    tick       = (tick_cnt_q == 5'(CYC_PER_US - 1));
    tick_cnt_d = tick ? 5'h00 : tick_cnt_q + 5'h01;
    link_stable = (link_cnt_q == LNK_W'(LINK_US));
    if (!link_up) begin
      link_cnt_d = '0;
    end else if (tick && !link_stable) begin
      link_cnt_d = link_cnt_q + LNK_W'(1);
    end else begin
      link_cnt_d = link_cnt_q;
    end
    eligible = !HOST_PORT && energy_saving_enable_q && speed_100
               && full_duplex && an_eee_100 && link_stable;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= 5'h00;
      link_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      link_cnt_q <= link_cnt_d;
    end
  end

  // client request from fifo idleness
  always_comb begin
    if (!energy_saving_enable_q || !tx_fifo_empty) begin
      empty_us_d = 32'h0000_0000;
    end else if (tick && empty_us_q != 32'hffff_ffff) begin
      empty_us_d = empty_us_q + 32'h0000_0001;
    end else begin
      empty_us_d = empty_us_q;
    end
    client_req = eligible && tx_fifo_empty
                 && (empty_us_q >= tx_idle_request_delay_q);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      empty_us_q <= 32'h0000_0000;
    end else begin
      empty_us_q <= empty_us_d;
    end
  end

  // phy-side idle sequencing, independent of the transmit enable bit
  always_comb begin
    state_d   = state_q;
    wake_us_d = wake_us_q;
    ipg_cnt_d = ipg_cnt_q;
    phy_tx_d  = mac_tx;
    unique case (state_q)
      ST_RUN: begin
        if (client_req && !mac_tx.en) begin
          state_d = ST_LPI;
        end
      end
      ST_LPI: begin
        if (!client_req) begin
          state_d   = ST_WAKE;
          wake_us_d = 32'h0000_0000;
          ipg_cnt_d = 5'h00;
        end
      end
      ST_WAKE: begin
        if (wake_us_q < tx_wake_wait_time_q) begin
          if (tick) begin
            wake_us_d = wake_us_q + 32'h0000_0001;
          end
        end else if (ipg_cnt_q == 5'(IPG_CYC - 1)) begin
          state_d = ST_RUN;
        end else begin
          ipg_cnt_d = ipg_cnt_q + 5'h01;
        end
      end
      default: state_d = ST_RUN;
    endcase
    if (state_d == ST_LPI) begin
      phy_tx_d = '{en: 1'b0, er: 1'b1, d: LPI_TXD};
    end else if (state_d == ST_WAKE) begin
      phy_tx_d = '{en: 1'b0, er: 1'b0, d: 4'h0};
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q   <= ST_RUN;
      wake_us_q <= 32'h0000_0000;
      ipg_cnt_q <= 5'h00;
      phy_tx_q  <= '0;
    end else begin
      state_q   <= state_d;
      wake_us_q <= wake_us_d;
      ipg_cnt_q <= ipg_cnt_d;
      phy_tx_q  <= phy_tx_d;
    end
  end

  // receive idle decode, regardless of the receive enable bit
  always_comb begin
    rx_lpi_now = eligible && !phy_rx.en && phy_rx.er
                 && (phy_rx.d == LPI_TXD);
  end

  // statistics counters
  always_comb begin
    tx_trans_d = tx_trans_q;
    tx_time_d  = tx_time_q;
    rx_trans_d = rx_trans_q;
    rx_time_d  = rx_time_q;
    if (!energy_saving_enable_q) begin
      tx_trans_d = '0;
      tx_time_d  = '0;
      rx_trans_d = '0;
      rx_time_d  = '0;
    end else begin
      if (state_q != ST_LPI && state_d == ST_LPI) begin
        tx_trans_d = tx_trans_q + CNT_W'(1);
      end
      if (state_q == ST_LPI && tick) begin
        tx_time_d = tx_time_q + CNT_W'(1);
      end
      if (rx_lpi_now && !rx_lpi_q) begin
        rx_trans_d = rx_trans_q + CNT_W'(1);
      end
      if (rx_lpi_q && tick) begin
        rx_time_d = rx_time_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_lpi_q   <= 1'b0;
      tx_trans_q <= '0;
      tx_time_q  <= '0;
      rx_trans_q <= '0;
      rx_time_q  <= '0;
    end else begin
      rx_lpi_q   <= rx_lpi_now;
      tx_trans_q <= tx_trans_d;
      tx_time_q  <= tx_time_d;
      rx_trans_q <= rx_trans_d;
      rx_time_q  <= rx_time_d;
    end
  end

  // register port; counters are read-only and keep their value on read
  always_comb begin
    energy_saving_enable_d  = energy_saving_enable_q;
    txe_d                   = txe_q;
    rxe_d                   = rxe_q;
    tx_idle_request_delay_d = tx_idle_request_delay_q;
    tx_wake_wait_time_d     = tx_wake_wait_time_q;
    rdata_d                 = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: begin
          energy_saving_enable_d = reg_wdata[CTRL_EN_BIT];
          txe_d                  = reg_wdata[CTRL_TXE_BIT];
          rxe_d                  = reg_wdata[CTRL_RXE_BIT];
        end
        REG_DELAY: tx_idle_request_delay_d = reg_wdata;
        REG_WAKE:  tx_wake_wait_time_d     = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:     rdata_d = {29'h0, rxe_q, txe_q, energy_saving_enable_q};
        REG_DELAY:    rdata_d = tx_idle_request_delay_q;
        REG_WAKE:     rdata_d = tx_wake_wait_time_q;
        REG_STATUS:   rdata_d = {26'h0, rx_lpi_q, state_q, link_stable,
                                 eligible};
        REG_TX_TRANS: rdata_d = 32'(tx_trans_q);
        REG_TX_TIME:  rdata_d = 32'(tx_time_q);
        REG_RX_TRANS: rdata_d = 32'(rx_trans_q);
        REG_RX_TIME:  rdata_d = 32'(rx_time_q);
        default:      rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      energy_saving_enable_q  <= 1'b0;
      txe_q                   <= 1'b0;
      rxe_q                   <= 1'b0;
      tx_idle_request_delay_q <= DELAY_RST;
      tx_wake_wait_time_q     <= WAKE_RST;
      rdata_q                 <= 32'h0000_0000;
    end else begin
      energy_saving_enable_q  <= energy_saving_enable_d;
      txe_q                   <= txe_d;
      rxe_q                   <= rxe_d;
      tx_idle_request_delay_q <= tx_idle_request_delay_d;
      tx_wake_wait_time_q     <= tx_wake_wait_time_d;
      rdata_q                 <= rdata_d;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_host_never: assert property (HOST_PORT |-> !eligible)
    else $error("idle eligible on host port");
  a_gate_cond: assert property (client_req |-> energy_saving_enable_q
    && speed_100 && full_duplex && an_eee_100)
    else $error("idle request without eligibility");
  a_link_gate: assert property (!link_stable |-> !client_req
    && !rx_lpi_now)
    else $error("idle before link stable");
  a_fifo_negate: assert property (!tx_fifo_empty |-> !client_req)
    else $error("request held with data in fifo");
  a_empty_reset: assert property ((!tx_fifo_empty
    || !energy_saving_enable_q) |=> empty_us_q == 32'h0)
    else $error("empty timer not restarted");
  a_lpi_code: assert property (state_q == ST_LPI |-> !phy_tx.en
    && phy_tx.er && phy_tx.d == LPI_TXD)
    else $error("wrong idle code on mii");
  a_frame_done: assert property ((state_q == ST_RUN && mac_tx.en)
    |=> state_q == ST_RUN)
    else $error("idle entered mid frame");
  a_wake_defer: assert property ((state_q == ST_LPI && !client_req)
    |=> !tx_start_ok [*8])
    else $error("frame allowed before wake and gap");
  a_tx_trans: assert property ((state_q != ST_LPI && state_d == ST_LPI
    && energy_saving_enable_q)
    |=> tx_trans_q == $past(tx_trans_q) + CNT_W'(1))
    else $error("transition count missed");
  a_disable_clr: assert property (!energy_saving_enable_q |=> tx_time_q == 0
    && tx_trans_q == 0 && rx_trans_q == 0 && rx_time_q == 0)
    else $error("counters not cleared while disabled");
  a_rx_time: assert property ((rx_lpi_q && tick && energy_saving_enable_q)
    |=> rx_time_q == $past(rx_time_q) + CNT_W'(1))
    else $error("receive idle time not counted");
  a_tx_time: assert property ((state_q == ST_LPI && tick
    && energy_saving_enable_q)
    |=> tx_time_q == $past(tx_time_q) + CNT_W'(1))
    else $error("transmit idle time not counted");
  a_rx_trans: assert property ((rx_lpi_now && !rx_lpi_q
    && energy_saving_enable_q)
    |=> rx_trans_q == $past(rx_trans_q) + CNT_W'(1))
    else $error("receive transition count missed");
  a_wake_quiet: assert property (state_q == ST_WAKE |-> !phy_tx.en
    && !phy_tx.er && !tx_start_ok)
    else $error("frame or idle code during wake wait");

  c_enter_lpi: cover property (state_q == ST_RUN ##1 state_q == ST_LPI);
  c_wake_done: cover property (state_q == ST_WAKE ##1 state_q == ST_RUN);
  c_rx_lpi:    cover property (!rx_lpi_q ##1 rx_lpi_q);
  c_rx_time:   cover property (rx_lpi_q && tick);
  c_frame:     cover property (state_q == ST_RUN && mac_tx.en);
endmodule
`default_nettype wire

//--- verilog/eeelpi_pkg.sv
`default_nettype none
package eeelpi_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned US_NS          = 1000;
  localparam int unsigned CYC_PER_US     = US_NS / CLK_PERIOD_NS;
  localparam int unsigned IPG_NS         = 960;
  localparam int unsigned IPG_CYC        =
    (IPG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LINK_STABLE_US = 1000000;

  // register map, byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_DELAY    = 8'h04;
  localparam logic [7:0] REG_WAKE     = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0c;
  localparam logic [7:0] REG_TX_TRANS = 8'h10;
  localparam logic [7:0] REG_TX_TIME  = 8'h14;
  localparam logic [7:0] REG_RX_TRANS = 8'h18;
  localparam logic [7:0] REG_RX_TIME  = 8'h1c;

  // control fields
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_TXE_BIT = 1;
  localparam int unsigned CTRL_RXE_BIT = 2;
  localparam logic [31:0] DELAY_RST    = 32'h0000_0000;
  localparam logic [31:0] WAKE_RST     = 32'h0000_0000;

  // mii low-power-idle code
  localparam logic [3:0] LPI_TXD = 4'h1;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } eeelpi_mii_s;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_LPI  = 3'b010,
    ST_WAKE = 3'b100
  } eeelpi_state_e;
endpackage
`default_nettype wire

//--- tb/eeelpi_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module eeelpi_phy_model
  import eeelpi_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          lpi_cmd,
  output eeelpi_pkg::eeelpi_mii_s rx
);
  import eeelpi_pkg::*;
  // phy side of the receive path, idle code only on command
  initial rx = '0;
  always @(posedge core_clk) begin
    if (lpi_cmd) begin
      rx <= '{en: 1'b0, er: 1'b1, d: 4'h1};
    end else begin
      rx <= '{en: 1'b0, er: 1'b0, d: 4'h0};
    end
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import eeelpi_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] e;
  } eeelpi_row_s;
  logic          core_clk      = 1'b0;
  logic          reset         = 1'b1;
  logic [7:0]    reg_addr      = 8'h00;
  logic [31:0]   reg_wdata     = 32'h0;
  logic          reg_wr        = 1'b0;
  logic          reg_rd        = 1'b0;
  logic [31:0]   reg_rdata;
  logic          tx_fifo_empty = 1'b1;
  eeelpi_mii_s   mac_tx        = '0;
  logic          tx_start_ok;
  eeelpi_mii_s   phy_tx;
  eeelpi_mii_s   phy_rx;
  logic          full_duplex   = 1'b0;
  logic          link_up       = 1'b1;
  logic          lpi_cmd       = 1'b0;
  logic          mac_transmit_enable;
  logic          mac_receive_enable;
  logic          rx_lpi_active;
  logic [31:0]   got;
  int            n_fail        = 0;
  int            check_count   = 0;
  int            n;
  eeelpi_row_s   rows [8];
  localparam logic [31:0] IDLE = 32'h0000_0011;

  always #20 core_clk = ~core_clk;

  eeelpi_port #(.LINK_US(3)) dut_u (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_fifo_empty(tx_fifo_empty),
    .mac_tx(mac_tx), .tx_start_ok(tx_start_ok), .phy_tx(phy_tx),
    .phy_rx(phy_rx), .link_up(link_up), .speed_100(1'b1),
    .full_duplex(full_duplex), .an_eee_100(1'b1),
    .mac_transmit_enable(mac_transmit_enable),
    .mac_receive_enable(mac_receive_enable),
    .rx_lpi_active(rx_lpi_active));

  eeelpi_phy_model phy_u (.core_clk(core_clk), .lpi_cmd(lpi_cmd),
    .rx(phy_rx));

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: flag %b want %b", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #(5000 * 40);
    n_fail++;
    close_out();
  end

  initial begin
    rows[0] = '{REG_CTRL, 32'h6, 32'h6};
    rows[1] = '{REG_DELAY, 32'h123, 32'h123};
    rows[2] = '{REG_WAKE, 32'h45, 32'h45};
    rows[3] = '{REG_TX_TRANS, 32'hffff, 32'h0};
    rows[4] = '{REG_TX_TIME, 32'hffff, 32'h0};
    rows[5] = '{REG_RX_TRANS, 32'hffff, 32'h0};
    rows[6] = '{REG_RX_TIME, 32'hffff, 32'h0};
    rows[7] = '{8'h20, 32'hffff, 32'h0};
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    #1 chk32({26'h0, phy_tx}, 32'h0);
    chkb(tx_start_ok, 1'b1);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, got);
      chk32(got, rows[i].e);
    end
    chkb(mac_transmit_enable, 1'b1);
    chkb(mac_receive_enable, 1'b1);
    // enable only, transmit and receive enables left clear
    wr(REG_WAKE, 32'h1);
    wr(REG_DELAY, 32'h0);
    wr(REG_CTRL, 32'h1);
    repeat (200) @(posedge core_clk);
    #1 chk32({26'h0, phy_tx}, 32'h0);
    @(posedge core_clk);
    full_duplex <= 1'b1;
    mac_tx      <= '{en: 1'b1, er: 1'b0, d: 4'h0};
    repeat (20) @(posedge core_clk);
    #1 chk32({26'h0, phy_tx}, 32'h20);
    @(posedge core_clk);
    mac_tx <= '0;
    for (n = 0; n < 8 && {26'h0, phy_tx} !== IDLE; n++) @(posedge core_clk);
    #1 chk32({26'h0, phy_tx}, IDLE);
    chkb(tx_start_ok, 1'b0);
    repeat (70) @(posedge core_clk);
    tx_fifo_empty <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk32({26'h0, phy_tx}, 32'h0);
    for (n = 2; n < 200 && tx_start_ok !== 1'b1; n++) @(posedge core_clk);
    chkb(n >= 25 && n <= 60, 1'b1);
    rd(REG_TX_TRANS, got);
    chk32(got, 32'h1);
    rd(REG_TX_TIME, got);
    chkb(got >= 1 && got <= 4, 1'b1);
    wr(REG_DELAY, 32'h3);
    tx_fifo_empty <= 1'b1;
    repeat (40) @(posedge core_clk);
    tx_fifo_empty <= 1'b0;
    @(posedge core_clk);
    tx_fifo_empty <= 1'b1;
    repeat (40) @(posedge core_clk);
    #1 chk32({26'h0, phy_tx}, 32'h0);
    for (n = 0; n < 80 && {26'h0, phy_tx} !== IDLE; n++) @(posedge core_clk);
    #1 chk32({26'h0, phy_tx}, IDLE);
    @(posedge core_clk);
    tx_fifo_empty <= 1'b0;
    wr(REG_CTRL, 32'h0);
    rd(REG_TX_TRANS, got);
    chk32(got, 32'h0);
    wr(REG_CTRL, 32'h1);
    lpi_cmd <= 1'b1;
    repeat (80) @(posedge core_clk);
    #1 chkb(rx_lpi_active, 1'b1);
    @(posedge core_clk);
    lpi_cmd <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chkb(rx_lpi_active, 1'b0);
    rd(REG_RX_TRANS, got);
    chk32(got, 32'h1);
    rd(REG_RX_TIME, got);
    chkb(got >= 2 && got <= 4, 1'b1);
    full_duplex <= 1'b0;
    lpi_cmd     <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1 chkb(rx_lpi_active, 1'b0);
    @(posedge core_clk);
    link_up     <= 1'b0;
    full_duplex <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1 chkb(rx_lpi_active, 1'b0);
    @(posedge core_clk);
    link_up <= 1'b1;
    repeat (45) @(posedge core_clk);
    #1 chkb(rx_lpi_active, 1'b0);
    repeat (60) @(posedge core_clk);
    #1 chkb(rx_lpi_active, 1'b1);
    wr(REG_CTRL, 32'h0);
    rd(REG_RX_TRANS, got);
    chk32(got, 32'h0);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    #1 chk32({26'h0, phy_tx}, 32'h0);
    rd(REG_DELAY, got);
    chk32(got, DELAY_RST);
    close_out();
  end
endmodule
`default_nettype wire
